// >>> rtl/ssa_top.sv
// Subtract and swap datapath slice with its APB register port.
//
// How it works
// - Literal minus work goes to work, flags updated.
// - File minus work, seven-bit address, flags updated.
// - Destination bit picks work or file register.
// - Carry set when no borrow, cleared when negative.
// - Swap nibbles to chosen destination, flags untouched.
`timescale 1ns/1ps
module ssa_top #(
    parameter int unsigned INSTR_DIV = ssa_pkg::INSTR_DIV_DEF
) (
    input  wire logic                            clk_sys_in,
    input  wire logic                            sys_rst_in,
    input  wire logic                            psel_in,
    input  wire logic                            penable_in,
    input  wire logic                            pwrite_in,
    input  wire logic [ssa_pkg::APB_ADDR_W-1:0]  paddr_in,
    input  wire logic [ssa_pkg::APB_DATA_W-1:0]  pwdata_in,
    input  wire logic [3:0]                      pstrb_in,
    output logic      [ssa_pkg::APB_DATA_W-1:0]  prdata_out,
    output logic                                 pready_out,
    output logic                                 pslverr_out,
    output logic                                 file_wr_stb_out,
    output logic      [6:0]                      file_wr_addr_out,
    output logic      [7:0]                      file_wr_data_out
);
    import ssa_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // The divider needs at least two system clocks per instruction cycle.
    generate
        if (INSTR_DIV < 2) begin : g_bad_div
            $error("INSTR_DIV must be at least two");
        end
    endgenerate

    localparam int unsigned DIV_W = $clog2(INSTR_DIV);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INSTR_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_ZERO = '0;

    // ------------------------------------------------------------------
    // Address decode helper
    // ------------------------------------------------------------------
    // Used by both the read path and the write path so they never disagree.
    function automatic logic reg_hit(input logic [APB_ADDR_W-1:0] addr,
                                     input logic [7:0]            off);
        return (addr == off);
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    ssa_state_e        state;
    ssa_state_e        next_state;
    logic [DIV_W-1:0]  div_cnt;
    logic [DIV_W-1:0]  next_div_cnt;
    logic [13:0]       instr;
    logic [13:0]       next_instr;
    logic [7:0]        work;
    logic [7:0]        next_work;
    logic [7:0]        file_data;
    logic [7:0]        next_file_data;
    logic              flag_c;
    logic              next_flag_c;
    logic              digit_carry_flag;
    logic              next_digit_carry_flag;
    logic              flag_z;
    logic              next_flag_z;
    logic              bad_op;
    logic              next_bad_op;
    logic              wb_done;
    logic              next_wb_done;
    logic [6:0]        wb_addr;
    logic [6:0]        next_wb_addr;
    logic [31:0]       next_prdata;
    logic              next_pslverr;
    logic              next_file_wr_stb;
    logic [6:0]        next_file_wr_addr;
    logic [7:0]        next_file_wr_data;

    logic              tick;
    logic              exec;
    logic              setup;
    logic              wr_acc;
    logic              mapped;
    logic              dest_file;
    ssa_op_e           op;

    ssa_alu_if alu_bus ();

    ssa_alu u_alu (
        .bus (alu_bus)
    );

    // ------------------------------------------------------------------
    // Bus phase and handshake
    // ------------------------------------------------------------------
    // A new instruction word is held off while the previous one is still
    // armed; stretching pready keeps the master waiting instead of losing
    // the word. Every other access completes in its first access cycle.
    always_comb begin
        setup      = psel_in && !penable_in;
        mapped     = reg_hit(paddr_in, OFF_INSTR)  || reg_hit(paddr_in, OFF_WORK) ||
                     reg_hit(paddr_in, OFF_STATUS) || reg_hit(paddr_in, OFF_FILE) ||
                     reg_hit(paddr_in, OFF_FILE_WB);
        pready_out = !(psel_in && pwrite_in && reg_hit(paddr_in, OFF_INSTR) &&
                       (state == SSA_ST_ARMED));
        wr_acc     = psel_in && penable_in && pwrite_in && pready_out;
    end

    // ------------------------------------------------------------------
    // Instruction cycle divider and operand steering
    // ------------------------------------------------------------------
    // The enable pulse marks the end of an instruction cycle; an armed
    // word executes on that edge and its results are in place for the
    // word that follows.
    always_comb begin
        tick         = (div_cnt == DIV_LAST);
        next_div_cnt = tick ? DIV_ZERO : div_cnt + DIV_W'(1);
        exec         = tick && (state == SSA_ST_ARMED);
        op           = ssa_decode(instr);
        dest_file    = instr[DEST_BIT];
        alu_bus.op   = exec ? op : SSA_OP_NONE;
        alu_bus.work = work;
        alu_bus.opa  = (op == SSA_OP_LIT) ? instr[7:0] : file_data;
    end

    // ------------------------------------------------------------------
    // Register and datapath next values
    // ------------------------------------------------------------------
    // Software writes are applied first and execution results then
    // override them, so an instruction that finishes in the same edge as
    // a bus write to the same register is never lost.
    always_comb begin
        next_state            = state;
        next_instr            = instr;
        next_work             = work;
        next_file_data        = file_data;
        next_flag_c           = flag_c;
        next_digit_carry_flag = digit_carry_flag;
        next_flag_z           = flag_z;
        next_bad_op           = bad_op;
        next_wb_done          = wb_done;
        next_wb_addr          = wb_addr;
        next_file_wr_stb      = 1'b0;
        next_file_wr_addr     = file_wr_addr_out;
        next_file_wr_data     = file_wr_data_out;

        // Software side of each register.
        if (wr_acc) begin
            if (reg_hit(paddr_in, OFF_INSTR)) begin
                if (pstrb_in[0]) begin
                    next_instr[7:0] = pwdata_in[7:0];
                end
                if (pstrb_in[1]) begin
                    next_instr[13:8] = pwdata_in[13:8];
                end
                next_state = SSA_ST_ARMED;
            end
            if (reg_hit(paddr_in, OFF_WORK) && pstrb_in[0]) begin
                next_work = pwdata_in[7:0];
            end
            if (reg_hit(paddr_in, OFF_FILE) && pstrb_in[0]) begin
                next_file_data = pwdata_in[7:0];
            end
            if (reg_hit(paddr_in, OFF_STATUS) && pstrb_in[0]) begin
                next_flag_c           = pwdata_in[STAT_CARRY];
                next_digit_carry_flag = pwdata_in[STAT_DIGIT];
                next_flag_z           = pwdata_in[STAT_ZERO];
                if (pwdata_in[STAT_BAD]) begin
                    next_bad_op = 1'b0;
                end
            end
            if (reg_hit(paddr_in, OFF_FILE_WB) && pstrb_in[1] && pwdata_in[WB_DONE_BIT]) begin
                next_wb_done = 1'b0;
            end
        end

        // Execution side; sticky sets come last so they win over a clear.
        if (exec) begin
            next_state = SSA_ST_IDLE;
            if (alu_bus.flags_we) begin
                next_flag_c           = alu_bus.carry;
                next_digit_carry_flag = alu_bus.digit;
                next_flag_z           = alu_bus.zero;
            end
            unique case (op)
                SSA_OP_LIT: begin
                    next_work = alu_bus.result;
                end
                SSA_OP_SUBF, SSA_OP_SWAP: begin
                    if (dest_file) begin
                        next_file_data    = alu_bus.result;
                        next_file_wr_stb  = 1'b1;
                        next_file_wr_addr = instr[6:0];
                        next_file_wr_data = alu_bus.result;
                        next_wb_done      = 1'b1;
                        next_wb_addr      = instr[6:0];
                    end else begin
                        next_work = alu_bus.result;
                    end
                end
                SSA_OP_NONE: begin
                    next_bad_op = 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Read data is captured at the end of the setup cycle so that it comes
    // from a flip-flop while the access still needs no wait state.
    always_comb begin
        next_prdata  = prdata_out;
        next_pslverr = pslverr_out;
        if (setup) begin
            next_prdata  = 32'h0000_0000;
            next_pslverr = !mapped;
            if (!pwrite_in) begin
                if (reg_hit(paddr_in, OFF_INSTR)) begin
                    next_prdata[13:0] = instr;
                end
                if (reg_hit(paddr_in, OFF_WORK)) begin
                    next_prdata[7:0] = work;
                end
                if (reg_hit(paddr_in, OFF_STATUS)) begin
                    next_prdata[STAT_CARRY] = flag_c;
                    next_prdata[STAT_DIGIT] = digit_carry_flag;
                    next_prdata[STAT_ZERO]  = flag_z;
                    next_prdata[STAT_BUSY]  = (state == SSA_ST_ARMED);
                    next_prdata[STAT_BAD]   = bad_op;
                end
                if (reg_hit(paddr_in, OFF_FILE)) begin
                    next_prdata[7:0] = file_data;
                end
                if (reg_hit(paddr_in, OFF_FILE_WB)) begin
                    next_prdata[6:0]         = wb_addr;
                    next_prdata[WB_DONE_BIT] = wb_done;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            state            <= SSA_ST_IDLE;
            div_cnt          <= DIV_ZERO;
            instr            <= INSTR_RST;
            work             <= WORK_RST;
            file_data        <= FILE_RST;
            flag_c           <= 1'b0;
            digit_carry_flag <= 1'b0;
            flag_z           <= 1'b0;
            bad_op           <= 1'b0;
            wb_done          <= 1'b0;
            wb_addr          <= 7'h00;
            prdata_out       <= 32'h0000_0000;
            pslverr_out      <= 1'b0;
            file_wr_stb_out  <= 1'b0;
            file_wr_addr_out <= 7'h00;
            file_wr_data_out <= 8'h00;
        end else begin
            state            <= next_state;
            div_cnt          <= next_div_cnt;
            instr            <= next_instr;
            work             <= next_work;
            file_data        <= next_file_data;
            flag_c           <= next_flag_c;
            digit_carry_flag <= next_digit_carry_flag;
            flag_z           <= next_flag_z;
            bad_op           <= next_bad_op;
            wb_done          <= next_wb_done;
            wb_addr          <= next_wb_addr;
            prdata_out       <= next_prdata;
            pslverr_out      <= next_pslverr;
            file_wr_stb_out  <= next_file_wr_stb;
            file_wr_addr_out <= next_file_wr_addr;
            file_wr_data_out <= next_file_wr_data;
        end
    end

endmodule

// >>> rtl/ssa_pkg.sv
// Shared constants, types and decode helpers for the subtract and swap datapath slice.
package ssa_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int unsigned APB_ADDR_W = 8;
    localparam int unsigned APB_DATA_W = 32;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_INSTR   = 8'h00;
    localparam logic [7:0] OFF_WORK    = 8'h04;
    localparam logic [7:0] OFF_STATUS  = 8'h08;
    localparam logic [7:0] OFF_FILE    = 8'h0c;
    localparam logic [7:0] OFF_FILE_WB = 8'h10;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned STAT_CARRY  = 0;
    localparam int unsigned STAT_DIGIT  = 1;
    localparam int unsigned STAT_ZERO   = 2;
    localparam int unsigned STAT_BUSY   = 3;
    localparam int unsigned STAT_BAD    = 4;
    localparam int unsigned WB_DONE_BIT = 8;
    localparam int unsigned DEST_BIT    = 7;

    // ------------------------------------------------------------------
    // Values after reset and cycle counts
    // ------------------------------------------------------------------
    localparam logic [13:0] INSTR_RST     = 14'h0000;
    localparam logic [7:0]  WORK_RST      = 8'h00;
    localparam logic [7:0]  FILE_RST      = 8'h00;
    localparam int unsigned INSTR_DIV_DEF = 4;

    // ------------------------------------------------------------------
    // Opcode patterns of the three supported words
    // ------------------------------------------------------------------
    localparam logic [4:0] PAT_LIT_SUB  = 5'h1e;
    localparam logic [5:0] PAT_FILE_SUB = 6'h02;
    localparam logic [5:0] PAT_SWAP     = 6'h0e;

    // Operation selected by a decoded instruction word.
    typedef enum logic [3:0] {
        SSA_OP_NONE = 4'b0001,
        SSA_OP_LIT  = 4'b0010,
        SSA_OP_SUBF = 4'b0100,
        SSA_OP_SWAP = 4'b1000
    } ssa_op_e;

    // Sequencer state: waiting for a word, or holding one for the next cycle.
    typedef enum logic [1:0] {
        SSA_ST_IDLE  = 2'b01,
        SSA_ST_ARMED = 2'b10
    } ssa_state_e;

    // Bit 8 of the literal form is a don't-care, so only bits 13:9 are compared.
    function automatic ssa_op_e ssa_decode(input logic [13:0] word);
        ssa_op_e op;
        op = SSA_OP_NONE;
        if (word[13:9] == PAT_LIT_SUB) begin
            op = SSA_OP_LIT;
        end else if (word[13:8] == PAT_FILE_SUB) begin
            op = SSA_OP_SUBF;
        end else if (word[13:8] == PAT_SWAP) begin
            op = SSA_OP_SWAP;
        end
        return op;
    endfunction

endpackage

// >>> rtl/ssa_alu_if.sv
// Operand and result bundle between the sequencer and the arithmetic unit.
`timescale 1ns/1ps
interface ssa_alu_if;
    ssa_pkg::ssa_op_e op;
    logic [7:0]       opa;
    logic [7:0]       work;
    logic [7:0]       result;
    logic             carry;
    logic             digit;
    logic             zero;
    logic             flags_we;

    modport alu  (input op, opa, work, output result, carry, digit, zero, flags_we);
    modport core (output op, opa, work, input result, carry, digit, zero, flags_we);
endinterface

// >>> rtl/ssa_alu.sv
// Combinational subtract and nibble swap unit.
`timescale 1ns/1ps
module ssa_alu (
    ssa_alu_if.alu bus
);
    import ssa_pkg::*;

    logic [8:0] diff;
    logic [4:0] low_diff;

    // ------------------------------------------------------------------
    // Two's complement subtract: opa plus inverted work plus one.
    // ------------------------------------------------------------------
    // The ninth bit is the inverted borrow, so it reads one when the
    // result is zero or positive and the wrapped value stays modulo 256.
    always_comb begin
        diff          = {1'b0, bus.opa} + {1'b0, ~bus.work} + 9'h001;
        low_diff      = {1'b0, bus.opa[3:0]} + {1'b0, ~bus.work[3:0]} + 5'h01;
        bus.result    = bus.opa;
        bus.carry     = 1'b0;
        bus.digit     = 1'b0;
        bus.zero      = 1'b0;
        bus.flags_we  = 1'b0;
        unique case (bus.op)
            SSA_OP_LIT, SSA_OP_SUBF: begin
                bus.result   = diff[7:0];
                bus.carry    = diff[8];
                bus.digit    = low_diff[4];
                bus.zero     = (diff[7:0] == 8'h00);
                bus.flags_we = 1'b1;
            end
            SSA_OP_SWAP: begin
                bus.result   = {bus.opa[3:0], bus.opa[7:4]};
                bus.flags_we = 1'b0;
            end
            SSA_OP_NONE: begin
                bus.flags_we = 1'b0;
            end
        endcase
    end

endmodule

// >>> tb/ssa_top_sva.sv
// Checker for the subtract and swap slice, bound to its top module.
`timescale 1ns/1ps
module ssa_top_sva #(
    parameter int unsigned INSTR_DIV = 4
) (
    input wire logic                           clk_sys_in,
    input wire logic                           sys_rst_in,
    input wire logic                           psel_in,
    input wire logic                           penable_in,
    input wire logic                           pwrite_in,
    input wire logic [ssa_pkg::APB_ADDR_W-1:0] paddr_in,
    input wire logic [ssa_pkg::APB_DATA_W-1:0] pwdata_in,
    input wire logic [3:0]                     pstrb_in,
    input wire logic [ssa_pkg::APB_DATA_W-1:0] prdata_out,
    input wire logic                           pready_out,
    input wire logic                           pslverr_out,
    input wire logic                           file_wr_stb_out,
    input wire logic [6:0]                     file_wr_addr_out,
    input wire logic [7:0]                     file_wr_data_out
);
    import ssa_pkg::*;
    // A stalled word waits at most one divider period plus two cycles.
    localparam int STALL_MAX = INSTR_DIV + 2;
    logic mapped;
    // Only the five word offsets are served; anything else must be refused.
    assign mapped = paddr_in inside {OFF_INSTR, OFF_WORK, OFF_STATUS, OFF_FILE, OFF_FILE_WB};
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    a_reset_quiet: assert property ($fell(sys_rst_in) |-> pready_out && !file_wr_stb_out)
        else $error("outputs not idle after reset");
    a_ready_idle: assert property (psel_in && !(pwrite_in && paddr_in == OFF_INSTR) |-> pready_out)
        else $error("pready low outside an instruction write");
    a_stall_bound: assert property (psel_in && penable_in && !pready_out |-> ##[1:STALL_MAX] pready_out)
        else $error("instruction write stalled too long");
    a_stall_holds: assert property (psel_in && penable_in && !pready_out |=> $stable(prdata_out))
        else $error("read data moved during a stall");
    a_err_unmapped: assert property (psel_in && !penable_in && !mapped |=> pslverr_out && prdata_out == 0)
        else $error("unmapped access not refused");
    a_ok_mapped: assert property (psel_in && !penable_in && mapped |=> !pslverr_out)
        else $error("mapped access refused");
    a_strobe_pulse: assert property (file_wr_stb_out |=> !file_wr_stb_out)
        else $error("writeback strobe longer than one cycle");
    a_wb_addr_hold: assert property ($changed(file_wr_addr_out) |-> file_wr_stb_out)
        else $error("writeback address moved without strobe");
    a_wb_data_hold: assert property ($changed(file_wr_data_out) |-> file_wr_stb_out)
        else $error("writeback data moved without strobe");
    c_stall: cover property (psel_in && penable_in && !pready_out);
    c_strobe: cover property (file_wr_stb_out);
    c_refused: cover property (pslverr_out && psel_in && penable_in);
endmodule

bind ssa_top ssa_top_sva #(.INSTR_DIV(INSTR_DIV)) u_sva (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .file_wr_stb_out(file_wr_stb_out),
    .file_wr_addr_out(file_wr_addr_out), .file_wr_data_out(file_wr_data_out)
);

// >>> tb/subtract_swap_alu_tb_top.sv
// Self-checking bench for the subtract and swap slice over its APB port.
`timescale 1ns/1ps
module subtract_swap_alu_tb_top;
    import ssa_pkg::*;
    // Eight clocks per instruction cycle guarantee that one of three words
    // written back to back finds its predecessor still armed and stalls.
    localparam int unsigned DIV   = 8;
    localparam int          LIMIT = 20000;
    logic        clk_sys_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        psel_in    = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in  = 1'b0;
    logic [7:0]  paddr_in   = 8'h00;
    logic [31:0] pwdata_in  = 32'h0;
    logic [3:0]  pstrb_in   = 4'h0;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic        file_wr_stb_out;
    logic [6:0]  file_wr_addr_out;
    logic [7:0]  file_wr_data_out;
    logic [6:0]  wb_addr = 7'h00;
    logic [7:0]  wb_data = 8'h00;
    int          stb_cnt = 0;
    int          n_fail = 0;
    int          num_checks = 0;
    int          cyc = 0;

    ssa_top #(.INSTR_DIV(DIV)) dut (
        .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .file_wr_stb_out(file_wr_stb_out), .file_wr_addr_out(file_wr_addr_out),
        .file_wr_data_out(file_wr_data_out)
    );

    // Clock of 4 ns period.
    always #2 clk_sys_in = ~clk_sys_in;

    // Record every writeback pulse so that missing or doubled pulses show.
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (file_wr_stb_out === 1'b1) begin
            stb_cnt <= stb_cnt + 1;
            wb_addr <= file_wr_addr_out;
            wb_data <= file_wr_data_out;
        end
        if (cyc == LIMIT) begin
            n_fail++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask

    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        pstrb_in <= s;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        @(posedge clk_sys_in);
        while (pready_out !== 1'b1 && n < 100) begin
            n++;
            @(posedge clk_sys_in);
        end
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, s, rd, err);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0, 4'h0, rd, err);
        check(nm, exp, rd);
        check({nm, " err"}, 32'h0, {31'h0, err});
    endtask

    // Issue one word and poll until the busy flag drops.
    task automatic run(input logic [13:0] w);
        logic [31:0] rd;
        logic        err;
        int          n;
        n = 0;
        wr(OFF_INSTR, {18'h0, w});
        do begin
            apb(1'b0, OFF_STATUS, 32'h0, 4'h0, rd, err);
            n++;
        end while (rd[STAT_BUSY] !== 1'b0 && n < 20);
    endtask

    function automatic logic [31:0] flg(input logic [7:0] a, input logic [7:0] w);
        flg = 32'h0;
        flg[STAT_CARRY] = (a >= w);
        flg[STAT_DIGIT] = (a[3:0] >= w[3:0]);
        flg[STAT_ZERO]  = (a == w);
    endfunction

    task automatic t_reset();
        logic [31:0] rd;
        logic        err;
        rdchk("instr", OFF_INSTR, 32'h0);
        rdchk("work", OFF_WORK, 32'h0);
        rdchk("status", OFF_STATUS, 32'h0);
        rdchk("file", OFF_FILE, 32'h0);
        rdchk("wb", OFF_FILE_WB, 32'h0);
        wr(8'h18, 32'h55);
        apb(1'b0, 8'h14, 32'h0, 4'h0, rd, err);
        check("unmapped err", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rd);
        $display("done t_reset");
    endtask

    // Literal minus work, bit 8 toggled on odd cases since it is a don't-care.
    task automatic t_lit();
        logic [7:0] ks [4] = '{8'h02, 8'h02, 8'h02, 8'h10};
        logic [7:0] ws [4] = '{8'h01, 8'h02, 8'h03, 8'h01};
        for (int i = 0; i < 4; i++) begin
            wr(OFF_WORK, {24'h0, ws[i]});
            run(14'h3c00 | (14'(i % 2) << 8) | {6'h0, ks[i]});
            rdchk("lit work", OFF_WORK, {24'h0, ks[i] - ws[i]});
            rdchk("lit flags", OFF_STATUS, flg(ks[i], ws[i]));
        end
        $display("done t_lit");
    endtask

    // File minus work; the last case sends the result to work instead.
    task automatic t_subf();
        logic [7:0] fs [4] = '{8'h03, 8'h02, 8'h01, 8'h09};
        int         c0;
        for (int i = 0; i < 4; i++) begin
            wr(OFF_FILE, {24'h0, fs[i]});
            wr(OFF_WORK, 32'h2);
            c0 = stb_cnt;
            run(14'h0200 | (i < 3 ? 14'h0080 : 14'h0) | 14'(8'h55 + i));
            rdchk("subf file", OFF_FILE, i < 3 ? {24'h0, fs[i] - 8'h2} : 32'h9);
            rdchk("subf work", OFF_WORK, i < 3 ? 32'h2 : 32'h7);
            rdchk("subf flags", OFF_STATUS, flg(fs[i], 8'h2));
            check("subf stb", 32'(c0 + (i < 3 ? 1 : 0)), 32'(stb_cnt));
        end
        check("wb addr", 32'h57, {25'h0, wb_addr});
        check("wb data", 32'hff, {24'h0, wb_data});
        rdchk("wb reg", OFF_FILE_WB, 32'h0000_0157);
        wr(OFF_FILE_WB, 32'h0000_0100, 4'h2);
        rdchk("wb clear", OFF_FILE_WB, 32'h57);
        $display("done t_subf");
    endtask

    // Nibble swap to both destinations with the flags left preset.
    task automatic t_swap();
        int c0;
        wr(OFF_FILE, 32'ha5);
        wr(OFF_STATUS, 32'h5);
        wr(OFF_WORK, 32'h0);
        run(14'h0e21);
        rdchk("swap work", OFF_WORK, 32'h5a);
        rdchk("swap file", OFF_FILE, 32'ha5);
        c0 = stb_cnt;
        run(14'h0ea1);
        rdchk("swap file d1", OFF_FILE, 32'h5a);
        rdchk("swap flags", OFF_STATUS, 32'h5);
        check("swap stb", 32'(c0 + 1), 32'(stb_cnt));
        check("swap wb", 32'h5a, {24'h0, wb_data});
        $display("done t_swap");
    endtask

    // Three words written back to back, then a bad word, then a masked write.
    task automatic t_misc();
        wr(OFF_WORK, 32'h1);
        wr(OFF_INSTR, 32'h3c02);
        wr(OFF_INSTR, 32'h3c03);
        run(14'h3c05);
        rdchk("b2b work", OFF_WORK, 32'h3);
        rdchk("b2b flags", OFF_STATUS, flg(8'h05, 8'h02));
        wr(OFF_STATUS, 32'h0);
        run(14'h0000);
        rdchk("bad status", OFF_STATUS, 32'h10);
        rdchk("bad work", OFF_WORK, 32'h3);
        wr(OFF_STATUS, 32'h10);
        wr(OFF_WORK, 32'h77, 4'h0);
        rdchk("bad clear", OFF_STATUS, 32'h0);
        rdchk("strobe off", OFF_WORK, 32'h3);
        $display("done t_misc");
    endtask

    // Main sequence: reset for 20 cycles, then each scenario in turn.
    initial begin
        repeat (20) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        t_reset();
        t_lit();
        t_subf();
        t_swap();
        t_misc();
        report_and_stop();
    end
endmodule
